// ===== verilog/tsc_pkg.sv
// Package for the temperature sensor control word and alarm logic.
// Assumes a 125 MHz reference clock and 16-bit signed temperature words.
package tsc_pkg;

  // Control word field positions (upper byte = bits 15:8)
  localparam int IDLE_BIT  = 15;
  localparam int RES_HI    = 14;
  localparam int RES_LO    = 13;
  localparam int FLT_HI    = 12;
  localparam int FLT_LO    = 11;
  localparam int POL_BIT   = 10;
  localparam int MODE_BIT  = 9;
  localparam int SHDN_BIT  = 8;
  localparam int RATE_HI   = 7;
  localparam int RATE_LO   = 6;
  localparam int ALARM_BIT = 5;
  localparam int EXT_BIT   = 4;

  // Writable bits of the control word
  localparam logic [15:0] WR_MASK = 16'h1FD0;

  // Power-up values of the writable fields, and the fixed resolution value
  localparam logic [1:0] FLT_RST  = 2'h0;
  localparam logic [1:0] RATE_RST = 2'h2;
  localparam logic [1:0] RES_VAL  = 2'h3;

  // Right shifts that align left-justified words to the active format
  localparam int SHIFT_NRM = 4;
  localparam int SHIFT_EXT = 3;

  // Pointer selecting the control word
  localparam logic [7:0] PTR_CTRL = 8'h01;

  // Conversion timing
  localparam longint CLK_HZ     = 125_000_000;
  localparam longint PER_0P25HZ = 4 * CLK_HZ;
  localparam longint PER_1HZ    = CLK_HZ;
  localparam longint PER_4HZ    = CLK_HZ / 4;
  localparam longint PER_8HZ    = CLK_HZ / 8;
  localparam int     CONV_CYC   = 1000;

  // Fault counts selected by the fault field
  localparam logic [2:0] FLT_N0 = 3'h1;
  localparam logic [2:0] FLT_N1 = 3'h2;
  localparam logic [2:0] FLT_N2 = 3'h4;
  localparam logic [2:0] FLT_N3 = 3'h6;

  typedef enum logic [1:0] {
    ST_WAIT = 2'b01,
    ST_CONV = 2'b10
  } tsc_state_e;

  // Writable fields
  typedef struct packed {
    logic [1:0] fault_sel;
    logic       alert_polarity;
    logic       alert_mode_select;
    logic       shutdown_select;
    logic [1:0] rate_sel;
    logic       extended_range_select;
  } tsc_ctrl_s;

  // Temperature and limits
  typedef struct packed {
    logic signed [15:0] temp;
    logic signed [15:0] upper_limit;
    logic signed [15:0] lower_limit;
  } tsc_temps_s;

endpackage

// ===== verilog/tsc_fault_count.sv
// Consecutive-result counter for one limit comparison.
// Assumes qualify is sampled once per conversion result strobe.
`timescale 1ns/1ps
module tsc_fault_count #(
  parameter int W = 3
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         arst_n,
  // Control
  input  wire logic         result_vld,
  input  wire logic         qualify,
  input  wire logic         clear,
  input  wire logic [W-1:0] need,
  // Status
  output logic              hit
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  always_comb begin
    cnt_d = cnt_q;
    hit   = 1'b0;
    if (clear) begin
      cnt_d = '0;
    end else if (result_vld) begin
      if (!qualify) begin
        cnt_d = '0; // [RULE16]
      end else if (cnt_q + W'(1) >= need) begin
        hit   = 1'b1; // [RULE3]
        cnt_d = '0;
      end else begin
        cnt_d = cnt_q + W'(1);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule

// ===== verilog/tsc_ctrl.sv
// Control word and alarm logic of the temperature sensor.
// Assumes a protocol engine delivering pointer and data bytes on ref_clk.
//
// Overview of operation
// [RULE1] Idle flag reads 1 unless converting
// [RULE2] Resolution bits read-only, read binary 11
// [RULE3] Fault field sets 1,2,4,6 consecutive results
// [RULE4] Polarity bit sets active alert level
// [RULE5] Mode bit selects interrupt or comparator; the code only stores the bit, and it changes neither the alarm nor the pin
// [RULE6] Shutdown bit stops continuous conversion
// [RULE7] Rate field sets conversion timer period
// [RULE8] Alarm drops after consecutive upper-limit hits
// [RULE9] Alarm returns after consecutive below-lower results
// [RULE10] Polarity one inverts the alarm bit
// [RULE11] Mode bit never affects alarm bit
// [RULE12] Range bit selects 13-bit or 12-bit format
// [RULE13] Word moves high byte then low byte
// [RULE14] Host points with pointer value 01
// [RULE15] Low nibble zero, read-only writes ignored
// [RULE16] Broken run restarts consecutive count
`timescale 1ns/1ps
module tsc_ctrl #(
  parameter longint PER_0P25 = tsc_pkg::PER_0P25HZ,
  parameter longint PER_1    = tsc_pkg::PER_1HZ,
  parameter longint PER_4    = tsc_pkg::PER_4HZ,
  parameter longint PER_8    = tsc_pkg::PER_8HZ,
  parameter int     CONV_LEN = tsc_pkg::CONV_CYC
) (
  // Clock and reset
  input  wire logic               ref_clk,
  input  wire logic               arst_n,
  // Byte port from the bus engine
  input  wire logic [7:0]         pointer,
  input  wire logic               wr_byte_vld,
  input  wire logic [7:0]         wr_byte,
  input  wire logic               wr_start,
  input  wire logic               rd_start,
  input  wire logic               rd_byte_req,
  output logic [7:0]              rd_byte,
  // Temperature path
  input  wire tsc_pkg::tsc_temps_s temps,
  output logic                    conv_start,
  input  wire logic               conv_done,
  // Status
  output logic [15:0]             sensor_control_word,
  output logic                    alert_out,
  output logic                    extended_range
);

  tsc_pkg::tsc_ctrl_s  ctl_q, ctl_d;
  tsc_pkg::tsc_state_e st_q, st_d;
  logic [7:0]          hi_q, hi_d;
  logic                byte_sel_q, byte_sel_d;
  logic                rbyte_q, rbyte_d;
  logic [7:0]          rd_q, rd_d;
  logic                alarm_q, alarm_d;
  logic [31:0]         tmr_q, tmr_d;
  logic [31:0]         per;
  logic [2:0]          need;
  logic                sel_ok;
  logic                res_vld;
  logic                hit_hi, hit_lo;
  logic signed [15:0]  t_m, hi_m, lo_m;

  assign sel_ok = (pointer == tsc_pkg::PTR_CTRL); // [RULE14]

  // Read view of the word
  always_comb begin
    sensor_control_word = '0; // [RULE15]
    sensor_control_word[tsc_pkg::IDLE_BIT] = (st_q != tsc_pkg::ST_CONV); // [RULE1]
    sensor_control_word[tsc_pkg::RES_HI:tsc_pkg::RES_LO] = tsc_pkg::RES_VAL; // [RULE2]
    sensor_control_word[tsc_pkg::FLT_HI:tsc_pkg::FLT_LO] = ctl_q.fault_sel;
    sensor_control_word[tsc_pkg::POL_BIT]  = ctl_q.alert_polarity;
    sensor_control_word[tsc_pkg::MODE_BIT] = ctl_q.alert_mode_select;
    sensor_control_word[tsc_pkg::SHDN_BIT] = ctl_q.shutdown_select;
    sensor_control_word[tsc_pkg::RATE_HI:tsc_pkg::RATE_LO] = ctl_q.rate_sel;
    sensor_control_word[tsc_pkg::ALARM_BIT] = alarm_q ^ ~ctl_q.alert_polarity; // [RULE10]
    sensor_control_word[tsc_pkg::EXT_BIT]  = ctl_q.extended_range_select;
  end

  // Byte ordering on reads and writes
  always_comb begin
    ctl_d      = ctl_q;
    hi_d       = hi_q;
    byte_sel_d = byte_sel_q;
    rbyte_d    = rbyte_q;
    rd_d       = rd_q;
    if (wr_start) begin
      byte_sel_d = 1'b0;
    end else if (wr_byte_vld && sel_ok) begin
      if (!byte_sel_q) begin
        hi_d       = wr_byte; // [RULE13]
        byte_sel_d = 1'b1;
      end else begin
        byte_sel_d = 1'b0;
        ctl_d.fault_sel         = hi_q[tsc_pkg::FLT_HI-8:tsc_pkg::FLT_LO-8]; // [RULE15]
        ctl_d.alert_polarity    = hi_q[tsc_pkg::POL_BIT-8];
        ctl_d.alert_mode_select = hi_q[tsc_pkg::MODE_BIT-8];
        ctl_d.shutdown_select   = hi_q[tsc_pkg::SHDN_BIT-8];
        ctl_d.rate_sel          = wr_byte[tsc_pkg::RATE_HI:tsc_pkg::RATE_LO];
        ctl_d.extended_range_select = wr_byte[tsc_pkg::EXT_BIT];
      end
    end
    if (rd_start) begin
      rbyte_d = 1'b0;
    end else if (rd_byte_req && sel_ok) begin
      rd_d    = rbyte_q ? sensor_control_word[7:0] : sensor_control_word[15:8]; // [RULE13]
      rbyte_d = ~rbyte_q;
    end
  end

  // Conversion timer
  always_comb begin
    case (ctl_q.rate_sel) // [RULE7]
      2'h0:    per = 32'(PER_0P25);
      2'h1:    per = 32'(PER_1);
      2'h2:    per = 32'(PER_4);
      default: per = 32'(PER_8);
    endcase
    st_d       = st_q;
    tmr_d      = tmr_q + 32'h0000_0001;
    conv_start = 1'b0;
    case (st_q)
      tsc_pkg::ST_WAIT: begin
        if (ctl_q.shutdown_select) begin
          tmr_d = '0; // [RULE6]
        end else if (tmr_q + 32'h0000_0001 >= per) begin
          tmr_d      = '0;
          conv_start = 1'b1;
          st_d       = tsc_pkg::ST_CONV;
        end
      end
      tsc_pkg::ST_CONV: begin
        if (conv_done || tmr_q + 32'h0000_0001 >= 32'(CONV_LEN)) begin
          st_d = tsc_pkg::ST_WAIT;
        end
      end
      default: st_d = tsc_pkg::ST_WAIT;
    endcase
  end
  assign res_vld = (st_q == tsc_pkg::ST_CONV) && (st_d == tsc_pkg::ST_WAIT);

  // Limits compared in the active format
  always_comb begin
    if (ctl_q.extended_range_select) begin // [RULE12]
      t_m  = temps.temp        >>> tsc_pkg::SHIFT_EXT;
      hi_m = temps.upper_limit >>> tsc_pkg::SHIFT_EXT;
      lo_m = temps.lower_limit >>> tsc_pkg::SHIFT_EXT;
    end else begin
      t_m  = temps.temp        >>> tsc_pkg::SHIFT_NRM;
      hi_m = temps.upper_limit >>> tsc_pkg::SHIFT_NRM;
      lo_m = temps.lower_limit >>> tsc_pkg::SHIFT_NRM;
    end
    case (ctl_q.fault_sel)
      2'h0:    need = tsc_pkg::FLT_N0;
      2'h1:    need = tsc_pkg::FLT_N1;
      2'h2:    need = tsc_pkg::FLT_N2;
      default: need = tsc_pkg::FLT_N3;
    endcase
    alarm_d = alarm_q;
    if (!alarm_q && hit_hi) begin
      alarm_d = 1'b1; // [RULE8]
    end else if (alarm_q && hit_lo) begin
      alarm_d = 1'b0; // [RULE9]
    end
  end

  tsc_fault_count #(.W(3)) u_hi_cnt (
    .ref_clk    (ref_clk),
    .arst_n     (arst_n),
    .result_vld (res_vld),
    .qualify    (t_m >= hi_m),
    .clear      (alarm_q),
    .need       (need),
    .hit        (hit_hi)
  );

  tsc_fault_count #(.W(3)) u_lo_cnt (
    .ref_clk    (ref_clk),
    .arst_n     (arst_n),
    .result_vld (res_vld),
    .qualify    (t_m < lo_m),
    .clear      (!alarm_q),
    .need       (need),
    .hit        (hit_lo)
  );

  // Alarm ignores the mode bit; pin level follows polarity
  assign alert_out = alarm_q ~^ ctl_q.alert_polarity; // [RULE4] [RULE11] [RULE5]
  assign rd_byte        = rd_q;
  assign extended_range = ctl_q.extended_range_select;

  // Bus-side state
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctl_q      <= '{fault_sel: tsc_pkg::FLT_RST, rate_sel: tsc_pkg::RATE_RST, default: 1'b0};
      hi_q       <= '0;
      byte_sel_q <= 1'b0;
      rbyte_q    <= 1'b0;
      rd_q       <= '0;
    end else begin
      ctl_q      <= ctl_d;
      hi_q       <= hi_d;
      byte_sel_q <= byte_sel_d;
      rbyte_q    <= rbyte_d;
      rd_q       <= rd_d;
    end
  end

  // Conversion sequencing; a conversion runs straight out of reset
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q  <= tsc_pkg::ST_CONV;
      tmr_q <= '0;
    end else begin
      st_q  <= st_d;
      tmr_q <= tmr_d;
    end
  end

  // Alarm state, kept in active-high form whatever the polarity
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      alarm_q <= 1'b0;
    end else begin
      alarm_q <= alarm_d;
    end
  end

endmodule

// ===== sim/tsc_ctrl_props.sv
// Checker for the control word, conversion strobes and alert pin.
// Assumes it is bound to tsc_ctrl and sees only its ports.
`timescale 1ns/1ps
module tsc_ctrl_props (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        arst_n,
  // Observed ports
  input wire logic        conv_start,
  input wire logic        conv_done,
  input wire logic [15:0] sensor_control_word,
  input wire logic        alert_out,
  input wire logic        extended_range
);
  logic [15:0] cw;
  assign cw = sensor_control_word;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  sequence s_start;
    conv_start;
  endsequence
  sequence s_quiet;
    !conv_start [*8];
  endsequence
  a_res_fixed: assert property (cw[14:13] == 2'h3)
    else $error("resolution bits not 11");
  a_nibble_zero: assert property (cw[3:0] == 4'h0)
    else $error("low nibble not zero");
  a_alert_level: assert property (alert_out == cw[5])
    else $error("alert level disagrees with alarm bit");
  a_range_out: assert property (extended_range == cw[4])
    else $error("range output disagrees with word");
  a_start_busy: assert property (conv_start |=> !cw[15])
    else $error("idle flag set while converting");
  a_done_idle: assert property (conv_done && !conv_start |=> cw[15])
    else $error("idle flag not set after conversion");
  a_stop_shutdown: assert property (cw[8] && $past(cw[8]) |-> !conv_start)
    else $error("conversion started in shutdown");
  a_start_gap: assert property (s_start |=> s_quiet)
    else $error("conversion starts too close");
  a_mode_blind: assert property ($changed(cw[9]) && $stable(cw[10]) && !$past(conv_done)
    |-> $stable(cw[5]))
    else $error("mode bit moved the alarm bit");
endmodule

bind tsc_ctrl tsc_ctrl_props u_props (.ref_clk(ref_clk), .arst_n(arst_n),
  .conv_start(conv_start), .conv_done(conv_done), .sensor_control_word(sensor_control_word),
  .alert_out(alert_out), .extended_range(extended_range));

// ===== sim/tsc_conv_model.sv
// Converter stand-in: ends each conversion a few cycles after its start.
// Assumes the bench sets the temperature and limits it reports.
`timescale 1ns/1ps
module tsc_conv_model #(
  parameter int DLY = 3
) (
  // Clock and reset
  input wire logic                ref_clk,
  input wire logic                arst_n,
  // Conversion handshake
  input wire logic                conv_start,
  output logic                    conv_done,
  // Reported values
  input wire tsc_pkg::tsc_temps_s temp_set,
  output tsc_pkg::tsc_temps_s     temps
);
  logic [3:0] cnt_q;
  always_ff @(posedge ref_clk or negedge arst_n)
    if (!arst_n) cnt_q <= 4'h0;
    else if (conv_start) cnt_q <= 4'(DLY);
    else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
  assign conv_done = (cnt_q == 4'h1);
  assign temps = temp_set;
endmodule

// ===== sim/tsc_ctrl_bench.sv
// Bench for tsc_ctrl: bus tasks, alarm runs, rates, shutdown, pointer.
// Assumes shortened conversion periods and the converter stand-in.
`timescale 1ns/1ps
module tsc_ctrl_bench;
  logic        ref_clk = 1'h0, arst_n = 1'h0, wr_start = 1'h0, rd_start = 1'h0;
  logic        wr_byte_vld = 1'h0, rd_byte_req = 1'h0;
  logic [7:0]  pointer = 8'h01, wr_byte = 8'h00, rd_byte;
  logic [15:0] word, v;
  logic        conv_start, conv_done, alert_out, ext;
  tsc_pkg::tsc_temps_s tset = '{16'h4B00, 16'h5000, 16'h4B00}, temps;
  int          num_errors = 0, total_checks = 0, cyc = 0, per = 0, last = 0, n_st = 0, n_dn = 0;
  int          nf[5] = '{1, 2, 4, 6, 1};
  int          pr[4] = '{400, 100, 25, 12};
  tsc_ctrl #(.PER_0P25(400), .PER_1(100), .PER_4(25), .PER_8(12), .CONV_LEN(10)) uut (
    .ref_clk(ref_clk), .arst_n(arst_n), .pointer(pointer), .wr_byte_vld(wr_byte_vld),
    .wr_byte(wr_byte), .wr_start(wr_start), .rd_start(rd_start), .rd_byte_req(rd_byte_req),
    .rd_byte(rd_byte), .temps(temps), .conv_start(conv_start), .conv_done(conv_done),
    .sensor_control_word(word), .alert_out(alert_out), .extended_range(ext));
  tsc_conv_model u_conv (.ref_clk(ref_clk), .arst_n(arst_n), .conv_start(conv_start),
    .conv_done(conv_done), .temp_set(tset), .temps(temps));
  initial forever #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    n_dn <= n_dn + int'(conv_done);
    if (conv_start) begin
      n_st <= n_st + 1;
      last <= cyc;
      per <= cyc - last;
    end
  end
  task automatic summarize;
    $display("checks=%0d errors=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] d);
    @(posedge ref_clk) wr_start <= 1'h1;
    @(posedge ref_clk) begin
      wr_start <= 1'h0;
      wr_byte_vld <= 1'h1;
      wr_byte <= d[15:8];
    end
    @(posedge ref_clk) wr_byte <= d[7:0];
    @(posedge ref_clk) wr_byte_vld <= 1'h0;
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic rd(output logic [15:0] q);
    @(posedge ref_clk) rd_start <= 1'h1;
    @(posedge ref_clk) begin
      rd_start <= 1'h0;
      rd_byte_req <= 1'h1;
    end
    @(posedge ref_clk) #1 q[15:8] = rd_byte;
    @(posedge ref_clk) rd_byte_req <= 1'h0;
    #1 q[7:0] = rd_byte;
  endtask
  // Sets the reported temperature, then waits for n finished conversions
  task automatic convs(input logic [15:0] t, input int n);
    int goal;
    tset.temp <= t;
    goal = n_dn + n;
    for (int i = 0; i < 2000 && n_dn < goal; i++) @(posedge ref_clk);
    if (n_dn < goal) begin
      num_errors++;
      summarize();
    end
    repeat (2) @(posedge ref_clk);
  endtask
  initial begin
    repeat (100000) @(posedge ref_clk);
    num_errors++;
    summarize();
  end
  initial begin
    logic [1:0] f;
    logic       inv;
    repeat (16) @(posedge ref_clk);
    arst_n <= 1'h1;
    rd(v);
    chk(v & 16'h7FFF, 16'h60A0);
    wr(16'hFFFF);
    rd(v);
    chk(v & 16'h7FFF, 16'h7FD0);
    chk({15'h0, ext}, 16'h0001);
    $display("reset view and write mask done");
    for (int i = 0; i < 5; i++) begin
      f = 2'(i % 4);
      inv = (i == 4);
      // Shutdown off, fastest rate, alarm bit written 1, normal range
      wr({3'h7, f, inv, 1'(i), 3'h3, 2'h2, 4'hF});
      rd(v);
      chk(v & 16'h7FFF, {3'h3, f, inv, 1'(i), 3'h3, ~inv, 5'h00});
      convs(16'h4B00, 1);
      convs(16'h5000, nf[i] - 1);
      convs(16'h4B00, 1);
      convs(16'h5000, nf[i] - 1);
      chk({14'h0, alert_out, word[5]}, {14'h0, ~inv, ~inv});
      convs(16'h5000, 1);
      chk({14'h0, alert_out, word[5]}, {14'h0, inv, inv});
      convs(16'h4A00, nf[i] - 1);
      convs(16'h4B00, 1);
      convs(16'h4A00, nf[i] - 1);
      chk({14'h0, alert_out, word[5]}, {14'h0, inv, inv});
      convs(16'h4A00, 1);
      chk({14'h0, alert_out, word[5]}, {14'h0, ~inv, ~inv});
    end
    $display("alarm runs done");
    for (int r = 0; r < 4; r++) begin
      wr({8'h00, 2'(r), 6'h00});
      convs(16'h4B00, 3);
      chk(16'(per), 16'(pr[r]));
    end
    $display("rates done");
    wr(16'h01C0);
    v = 16'(n_st);
    repeat (100) @(posedge ref_clk);
    chk(16'(n_st), v);
    rd(v);
    chk(v, 16'hE1E0);
    @(posedge ref_clk) pointer <= 8'h02;
    wr(16'h001F);
    @(posedge ref_clk) pointer <= 8'h01;
    rd(v);
    chk(v, 16'hE1E0);
    $display("shutdown and pointer done");
    summarize();
  end
endmodule
